// ===== logic/ctsv_top.sv
// Notes on behaviour
// - All conditions hold: run timer, alarm on expiry
// - Any phase above upper limit stops supervision
// - All phases below lower limit stop supervision
// - Residual selected adds summed-versus-measured check
// - Small residual difference prevents the alarm
// - Four status events, store mask picks kinds
// - Every event carries a time stamp
// - Alarm and block counts, user clearable
// - Ring of twelve newest fault records
// - Record holds stamp, event, currents, code, group
// - Record holds time left before alarm
// - Block stops start, resets running start
// - Min to max phase ratio threshold
// - Negative to positive sequence ratio threshold
// - Alarm delay in five millisecond steps
`timescale 1ns/1ps
`default_nettype none
module ctsv_top
   import ctsv_pkg::*;
#(
   parameter int STEP_CYC = STEP_CYCLES
)(
   // Clock and reset
   input wire logic sys_clk,
   input wire logic nrst,
   input wire logic clk_en,
   // Measurements, one strobe per program cycle
   input wire logic meas_valid,
   input wire logic [CUR_W-1:0] cur_l1,
   input wire logic [CUR_W-1:0] cur_l2,
   input wire logic [CUR_W-1:0] cur_l3,
   input wire logic [CUR_W-1:0] measured_residual_current,
   input wire logic [CUR_W-1:0] summed_residual_current,
   input wire logic [CUR_W-1:0] seq_pos_current,
   input wire logic [CUR_W-1:0] seq_neg_current,
   // Settings
   input wire logic [CUR_W-1:0] phase_pickup_limit_high,
   input wire logic [CUR_W-1:0] phase_pickup_limit_low,
   input wire logic [PCT_W-1:0] phase_ratio_limit,
   input wire logic [PCT_W-1:0] sequence_unbalance_ratio,
   input wire logic [CUR_W-1:0] residual_diff_limit,
   input wire logic residual_sel,
   input wire logic [DLY_W-1:0] alarm_delay,
   input wire logic [1:0] event_store_sel,
   input wire logic [GRP_W-1:0] set_group,
   // Control
   input wire logic block_in,
   input wire logic count_clear,
   input wire logic [TS_W-1:0] time_stamp,
   // Record read
   input wire logic rec_rd_en,
   input wire logic [IDX_W-1:0] rec_rd_age,
   // Status
   output logic start_ff,
   output logic alarm_ff,
   output logic blocked_ff,
   output logic [FLT_W-1:0] cond_ff,
   // Events
   output logic [EVT_W-1:0] evt_ff,
   output logic [TS_W-1:0] evt_stamp_ff,
   // Counters
   output logic [CNT_W-1:0] alarm_cnt_ff,
   output logic [CNT_W-1:0] block_cnt_ff,
   // Records
   output logic [IDX_W-1:0] rec_count_ff,
   output ctsv_rec_t rec_rd_data
);
   // ==========================================================
   // Helpers
   function automatic logic frac_ge(input logic [CUR_W-1:0] num, input logic [CUR_W-1:0] den,
      input logic [PCT_W-1:0] pct);
      logic [31:0] lhs;
      logic [31:0] rhs;
      lhs = 32'(num) * 32'(PCT_FULL);
      rhs = 32'(den) * 32'(pct);
      return lhs >= rhs;
   endfunction

   function automatic logic frac_le(input logic [CUR_W-1:0] num, input logic [CUR_W-1:0] den,
      input logic [PCT_W-1:0] pct);
      logic [31:0] lhs;
      logic [31:0] rhs;
      lhs = 32'(num) * 32'(PCT_FULL);
      rhs = 32'(den) * 32'(pct);
      return lhs <= rhs;
   endfunction

   function automatic logic [CUR_W-1:0] abs_diff(input logic [CUR_W-1:0] a,
      input logic [CUR_W-1:0] b);
      return (a >= b) ? a - b : b - a;
   endfunction

   function automatic logic [CUR_W-1:0] max3(input logic [CUR_W-1:0] a,
      input logic [CUR_W-1:0] b, input logic [CUR_W-1:0] c);
      logic [CUR_W-1:0] m;
      m = (a > b) ? a : b;
      return (m > c) ? m : c;
   endfunction

   function automatic logic [CUR_W-1:0] min3(input logic [CUR_W-1:0] a,
      input logic [CUR_W-1:0] b, input logic [CUR_W-1:0] c);
      logic [CUR_W-1:0] m;
      m = (a < b) ? a : b;
      return (m < c) ? m : c;
   endfunction

   function automatic logic [IDX_W-1:0] ring_step(input logic [IDX_W-1:0] p);
      return (p == IDX_W'(REC_DEPTH - 1)) ? '0 : p + 4'h1;
   endfunction

   // ==========================================================
   // Pickup conditions
   logic [CUR_W-1:0] i_max;
   logic [CUR_W-1:0] i_min;
   logic [FLT_W-1:0] nxt_cond;
   logic pickup;

   assign i_max = max3(cur_l1, cur_l2, cur_l3);
   assign i_min = min3(cur_l1, cur_l2, cur_l3);

   always_comb begin
      nxt_cond = '0;
      nxt_cond[FC_HIGH] = (i_max <= phase_pickup_limit_high);
      nxt_cond[FC_LOW] = (i_max >= phase_pickup_limit_low);
      // Min over max at or below the setting; a lost phase gives zero and passes
      nxt_cond[FC_RATIO] = frac_le(i_min, i_max, phase_ratio_limit);
      nxt_cond[FC_SEQ] = frac_ge(seq_neg_current, seq_pos_current,
         sequence_unbalance_ratio);
      // Residual check only counts when the residual input is selected
      nxt_cond[FC_RES] = !residual_sel ||
         (abs_diff(summed_residual_current, measured_residual_current)
         >= residual_diff_limit);
   end

   // Conditions are sampled once per program cycle
   always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         cond_ff <= '0;
      end else if (clk_en && meas_valid) begin
         cond_ff <= nxt_cond;
      end
   end

   // Record currents come from the strobed sample; pins are not valid between strobes
   logic [CUR_W-1:0] l1_ff;
   logic [CUR_W-1:0] l2_ff;
   logic [CUR_W-1:0] l3_ff;
   logic [CUR_W-1:0] res_meas_ff;
   logic [CUR_W-1:0] res_calc_ff;
   logic [CUR_W-1:0] seq_pos_ff;
   logic [CUR_W-1:0] seq_neg_ff;

   always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         l1_ff <= '0;
         l2_ff <= '0;
         l3_ff <= '0;
         res_meas_ff <= '0;
         res_calc_ff <= '0;
         seq_pos_ff <= '0;
         seq_neg_ff <= '0;
      end else if (clk_en && meas_valid) begin
         l1_ff <= cur_l1;
         l2_ff <= cur_l2;
         l3_ff <= cur_l3;
         res_meas_ff <= measured_residual_current;
         res_calc_ff <= summed_residual_current;
         seq_pos_ff <= seq_pos_current;
         seq_neg_ff <= seq_neg_current;
      end
   end

   assign pickup = &cond_ff;

   // ==========================================================
   // Start, block and alarm
   logic nxt_start;
   logic nxt_blocked;
   logic nxt_alarm;
   logic tmr_expired;
   logic [DLY_W-1:0] tmr_left;
   logic [DLY_W-1:0] delay_lim;

   assign delay_lim = (alarm_delay > ALARM_DELAY_MAX) ? ALARM_DELAY_MAX : alarm_delay;
   assign nxt_start = pickup && !block_in;
   assign nxt_blocked = pickup && block_in;
   // Alarm drops with the start, never waits for a release delay
   assign nxt_alarm = start_ff && tmr_expired;

   always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         start_ff <= 1'b0;
         blocked_ff <= 1'b0;
      end else if (clk_en) begin
         start_ff <= nxt_start;
         blocked_ff <= nxt_blocked;
      end
   end

   always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         alarm_ff <= 1'b0;
      end else if (clk_en) begin
         alarm_ff <= nxt_alarm && nxt_start;
      end
   end

   ctsv_dt_timer #(
      .STEP_CYC(STEP_CYC)
   ) u_timer (
      .sys_clk(sys_clk),
      .nrst(nrst),
      .clk_en(clk_en),
      .run(start_ff),
      .delay(delay_lim),
      .expired(tmr_expired),
      .remaining(tmr_left)
   );

   // ==========================================================
   // Events
   logic [EVT_W-1:0] nxt_evt_raw;
   logic [EVT_W-1:0] nxt_evt;
   logic nxt_alarm_q;

   assign nxt_alarm_q = nxt_alarm && nxt_start;

   always_comb begin
      nxt_evt_raw = '0;
      nxt_evt_raw[EV_ALARM_ON] = nxt_alarm_q && !alarm_ff;
      nxt_evt_raw[EV_ALARM_OFF] = !nxt_alarm_q && alarm_ff;
      nxt_evt_raw[EV_BLOCK_ON] = nxt_blocked && !blocked_ff;
      nxt_evt_raw[EV_BLOCK_OFF] = !nxt_blocked && blocked_ff;
      nxt_evt = nxt_evt_raw;
      if (!event_store_sel[STORE_ON]) begin
         nxt_evt[EV_ALARM_ON] = 1'b0;
         nxt_evt[EV_BLOCK_ON] = 1'b0;
      end
      if (!event_store_sel[STORE_OFF]) begin
         nxt_evt[EV_ALARM_OFF] = 1'b0;
         nxt_evt[EV_BLOCK_OFF] = 1'b0;
      end
   end

   // Two events may fire together, so each has its own bit
   always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         evt_ff <= '0;
         evt_stamp_ff <= '0;
      end else if (clk_en) begin
         evt_ff <= nxt_evt;
         if (|nxt_evt) begin
            evt_stamp_ff <= time_stamp;
         end
      end
   end

   // ==========================================================
   // Cumulative counters, a new event wins over a clear
   always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         alarm_cnt_ff <= '0;
         block_cnt_ff <= '0;
      end else if (clk_en) begin
         if (nxt_evt_raw[EV_ALARM_ON]) begin
            alarm_cnt_ff <= count_clear ? 16'h0001 : alarm_cnt_ff + 16'h0001;
         end else if (count_clear) begin
            alarm_cnt_ff <= '0;
         end
         if (nxt_evt_raw[EV_BLOCK_ON]) begin
            block_cnt_ff <= count_clear ? 16'h0001 : block_cnt_ff + 16'h0001;
         end else if (count_clear) begin
            block_cnt_ff <= '0;
         end
      end
   end

   // ==========================================================
   // Fault record ring
   ctsv_rec_if rec_bus ();
   logic [IDX_W-1:0] wr_ptr_ff;
   logic rec_trig;
   logic [IDX_W-1:0] back;
   ctsv_rec_t nxt_rec;

   // Records are written for the assertion events only
   assign rec_trig = nxt_evt_raw[EV_ALARM_ON] || nxt_evt_raw[EV_BLOCK_ON];

   always_comb begin
      nxt_rec = '0;
      nxt_rec.stamp = time_stamp;
      nxt_rec.event_code = nxt_evt_raw;
      nxt_rec.cur_l1 = l1_ff;
      nxt_rec.cur_l2 = l2_ff;
      nxt_rec.cur_l3 = l3_ff;
      nxt_rec.res_meas = res_meas_ff;
      nxt_rec.res_calc = res_calc_ff;
      nxt_rec.seq_pos = seq_pos_ff;
      nxt_rec.seq_neg = seq_neg_ff;
      nxt_rec.time_left = start_ff ? tmr_left : delay_lim;
      nxt_rec.fault_code = cond_ff;
      nxt_rec.set_group = set_group;
   end

   always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         wr_ptr_ff <= '0;
         rec_count_ff <= '0;
      end else if (clk_en && rec_trig) begin
         wr_ptr_ff <= ring_step(wr_ptr_ff);
         if (rec_count_ff != IDX_W'(REC_DEPTH)) begin
            rec_count_ff <= rec_count_ff + 4'h1;
         end
      end
   end

   // Age 0 is the newest record; ages beyond the depth wrap modulo twelve
   always_comb begin
      back = (rec_rd_age >= IDX_W'(REC_DEPTH)) ? rec_rd_age - IDX_W'(REC_DEPTH) : rec_rd_age;
      if (wr_ptr_ff > back) begin
         rec_bus.rd_addr = wr_ptr_ff - back - 4'h1;
      end else begin
         rec_bus.rd_addr = wr_ptr_ff + IDX_W'(REC_DEPTH) - back - 4'h1;
      end
   end

   assign rec_bus.wr_en = rec_trig;
   assign rec_bus.wr_addr = wr_ptr_ff;
   assign rec_bus.wr_data = nxt_rec;
   assign rec_bus.rd_en = rec_rd_en;
   assign rec_rd_data = rec_bus.rd_data;

   // Separate instance per block keeps each set of records private
   ctsv_rec_mem u_mem (
      .sys_clk(sys_clk),
      .nrst(nrst),
      .clk_en(clk_en),
      .rec(rec_bus.mem)
   );
endmodule // ctsv_top
`default_nettype wire

// ===== logic/ctsv_pkg.sv
package ctsv_pkg;
   // ==========================================================
   // Widths
   localparam int CUR_W = 16;
   localparam int PCT_W = 14;
   localparam int DLY_W = 19;
   localparam int TS_W = 48;
   localparam int GRP_W = 3;
   localparam int FLT_W = 5;
   localparam int CNT_W = 16;
   localparam int EVT_W = 4;
   localparam int REC_DEPTH = 12;
   localparam int IDX_W = 4;
   // ==========================================================
   // Setting scales and defaults
   localparam logic [PCT_W-1:0] PCT_FULL = 14'h2710;
   localparam logic [PCT_W-1:0] RATIO_DEF = 14'h03E8;
   localparam logic [PCT_W-1:0] SEQ_RATIO_DEF = 14'h1324;
   localparam logic [DLY_W-1:0] ALARM_DELAY_DEF = 19'h00064;
   localparam logic [DLY_W-1:0] ALARM_DELAY_MAX = 19'h57E40;
   // ==========================================================
   // Timing
   localparam int CLK_PERIOD_NS = 10;
   localparam int STEP_TIME_NS = 5000000;
   localparam int STEP_CYCLES = STEP_TIME_NS / CLK_PERIOD_NS;
   // ==========================================================
   // Event vector positions
   localparam int EV_ALARM_ON = 0;
   localparam int EV_ALARM_OFF = 1;
   localparam int EV_BLOCK_ON = 2;
   localparam int EV_BLOCK_OFF = 3;
   // Store mask positions
   localparam int STORE_ON = 0;
   localparam int STORE_OFF = 1;
   // Fault status code bit positions
   localparam int FC_HIGH = 0;
   localparam int FC_LOW = 1;
   localparam int FC_RATIO = 2;
   localparam int FC_SEQ = 3;
   localparam int FC_RES = 4;
   // ==========================================================
   // Fault record layout
   typedef struct packed {
      logic [TS_W-1:0] stamp;
      logic [EVT_W-1:0] event_code;
      logic [CUR_W-1:0] cur_l1;
      logic [CUR_W-1:0] cur_l2;
      logic [CUR_W-1:0] cur_l3;
      logic [CUR_W-1:0] res_meas;
      logic [CUR_W-1:0] res_calc;
      logic [CUR_W-1:0] seq_pos;
      logic [CUR_W-1:0] seq_neg;
      logic [DLY_W-1:0] time_left;
      logic [FLT_W-1:0] fault_code;
      logic [GRP_W-1:0] set_group;
   } ctsv_rec_t;
   localparam int REC_W = $bits(ctsv_rec_t);
endpackage

// ===== logic/ctsv_rec_if.sv
`timescale 1ns/1ps
`default_nettype none
interface ctsv_rec_if;
   import ctsv_pkg::*;
   logic wr_en;
   logic [IDX_W-1:0] wr_addr;
   ctsv_rec_t wr_data;
   logic rd_en;
   logic [IDX_W-1:0] rd_addr;
   ctsv_rec_t rd_data;
   modport ctl (output wr_en, output wr_addr, output wr_data, output rd_en, output rd_addr,
      input rd_data);
   modport mem (input wr_en, input wr_addr, input wr_data, input rd_en, input rd_addr,
      output rd_data);
endinterface
`default_nettype wire

// ===== logic/ctsv_rec_mem.sv
`timescale 1ns/1ps
`default_nettype none
module ctsv_rec_mem
   import ctsv_pkg::*;
(
   // Clock and reset
   input wire logic sys_clk,
   input wire logic nrst,
   input wire logic clk_en,
   // Record port
   ctsv_rec_if.mem rec
);
   // ==========================================================
   // Storage, read data from a register
   ctsv_rec_t mem_ff [REC_DEPTH];
   ctsv_rec_t rd_ff;

   always_ff @(posedge sys_clk) begin
      if (clk_en && rec.wr_en) begin
         mem_ff[rec.wr_addr] <= rec.wr_data;
      end
   end

   always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         rd_ff <= '0;
      end else if (clk_en && rec.rd_en) begin
         rd_ff <= mem_ff[rec.rd_addr];
      end
   end

   assign rec.rd_data = rd_ff;
endmodule // ctsv_rec_mem
`default_nettype wire

// ===== logic/ctsv_dt_timer.sv
`timescale 1ns/1ps
`default_nettype none
module ctsv_dt_timer
   import ctsv_pkg::*;
#(
   parameter int STEP_CYC = STEP_CYCLES
)(
   // Clock and reset
   input wire logic sys_clk,
   input wire logic nrst,
   input wire logic clk_en,
   // Control
   input wire logic run,
   input wire logic [DLY_W-1:0] delay,
   // Status
   output logic expired,
   output logic [DLY_W-1:0] remaining
);
   // ==========================================================
   // Step prescaler and elapsed steps
   logic [31:0] pre_ff;
   logic [DLY_W-1:0] elapsed_ff;
   logic step;

   assign step = (pre_ff == 32'(STEP_CYC - 1));

   always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         pre_ff <= '0;
      end else if (clk_en) begin
         pre_ff <= (!run || step) ? '0 : pre_ff + 32'h1;
      end
   end

   // Stops counting once the delay is reached so a long hold cannot wrap
   always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         elapsed_ff <= '0;
      end else if (clk_en) begin
         if (!run) begin
            elapsed_ff <= '0;
         end else if (step && !expired) begin
            elapsed_ff <= elapsed_ff + 19'h00001;
         end
      end
   end

   assign expired = run && (elapsed_ff >= delay);
   assign remaining = expired ? '0 : delay - elapsed_ff;
endmodule // ctsv_dt_timer
`default_nettype wire

// ===== test/ctsv_meas_model.sv
`timescale 1ns/1ps
`default_nettype none
// ==========================================================
// Measurement front end: one strobe per program cycle
module ctsv_meas_model
   import ctsv_pkg::*;
(
   // Clock
   input wire logic sys_clk,
   // Setup from the bench
   input wire logic [3:0] per,
   input wire logic [CUR_W-1:0] v [7],
   // Toward the block
   output logic meas_valid,
   output logic [CUR_W-1:0] q [7]
);
   logic [3:0] cnt_ff = 4'h0;
   logic stb_ff = 1'b0;
   assign meas_valid = stb_ff;
   // Junk between strobes, so stale samples cannot pass unnoticed
   always_comb begin
      for (int i = 0; i < 7; i++) q[i] = stb_ff ? v[i] : ~v[i];
   end
   always @(negedge sys_clk) begin
      cnt_ff <= (cnt_ff >= per) ? 4'h0 : cnt_ff + 4'h1;
      stb_ff <= (cnt_ff == 4'h0);
   end
endmodule // ctsv_meas_model
`default_nettype wire

// ===== test/ctsv_top_chk.sv
`timescale 1ns/1ps
`default_nettype none
// ==========================================================
// Port checker
module ctsv_top_chk
   import ctsv_pkg::*;
(
   // Clock and reset
   input wire logic sys_clk,
   input wire logic nrst,
   // Inputs
   input wire logic clk_en,
   input wire logic meas_valid,
   input wire logic [CUR_W-1:0] cur_l1,
   input wire logic [CUR_W-1:0] cur_l2,
   input wire logic [CUR_W-1:0] cur_l3,
   input wire logic [CUR_W-1:0] phase_pickup_limit_high,
   input wire logic [CUR_W-1:0] phase_pickup_limit_low,
   input wire logic residual_sel,
   input wire logic block_in,
   // Outputs
   input wire logic start_ff,
   input wire logic alarm_ff,
   input wire logic blocked_ff,
   input wire logic [FLT_W-1:0] cond_ff,
   input wire logic [IDX_W-1:0] rec_count_ff
);
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!nrst);
   wire logic tk = clk_en && meas_valid;
   wire logic [CUR_W-1:0] hl = phase_pickup_limit_high;
   wire logic [CUR_W-1:0] ll = phase_pickup_limit_low;
   property p_start_cause;
      start_ff |-> $past(cond_ff) == 5'h1F;
   endproperty
   a_start_cause: assert property (p_start_cause)
      else $error("start without full condition set");
   property p_loss_clears;
      clk_en && cond_ff != 5'h1F |=> !start_ff && !alarm_ff;
   endproperty
   a_loss_clears: assert property (p_loss_clears)
      else $error("condition lost but start or alarm kept");
   property p_alarm_after_start;
      $rose(alarm_ff) |-> $past(start_ff) && start_ff;
   endproperty
   a_alarm_after_start: assert property (p_alarm_after_start)
      else $error("alarm without running start");
   property p_high;
      tk && (cur_l1 > hl || cur_l2 > hl || cur_l3 > hl) |=> !cond_ff[FC_HIGH];
   endproperty
   a_high: assert property (p_high)
      else $error("phase above upper limit accepted");
   property p_low;
      tk && cur_l1 < ll && cur_l2 < ll && cur_l3 < ll |=> !cond_ff[FC_LOW];
   endproperty
   a_low: assert property (p_low)
      else $error("all phases low accepted");
   property p_res_off;
      tk && !residual_sel |=> cond_ff[FC_RES];
   endproperty
   a_res_off: assert property (p_res_off)
      else $error("residual check active while deselected");
   property p_block;
      clk_en && block_in && cond_ff == 5'h1F |=> blocked_ff && !start_ff;
   endproperty
   a_block: assert property (p_block)
      else $error("block did not stop start");
   property p_ring;
      rec_count_ff <= 4'hC;
   endproperty
   a_ring: assert property (p_ring)
      else $error("record count above ring size");
   c_alarm: cover property ($rose(alarm_ff));
   c_block: cover property ($rose(blocked_ff));
   c_full: cover property (rec_count_ff == 4'hC);
endmodule // ctsv_top_chk
bind ctsv_top ctsv_top_chk u_chk (.sys_clk, .nrst, .clk_en, .meas_valid, .cur_l1, .cur_l2,
   .cur_l3, .phase_pickup_limit_high, .phase_pickup_limit_low, .residual_sel, .block_in,
   .start_ff, .alarm_ff, .blocked_ff, .cond_ff, .rec_count_ff);
`default_nettype wire

// ===== test/ctsv_top_tb.sv
`timescale 1ns/1ps
`default_nettype none
module ctsv_top_tb;
   import ctsv_pkg::*;
   // Short step keeps the delay scenarios within a few dozen cycles
   localparam int SC = 4;
   // ==========================================================
   // Signals
   logic sys_clk = 1'b0;
   logic nrst = 1'b0;
   logic clk_en = 1'b1;
   logic meas_valid;
   logic [3:0] per = 4'h3;
   logic [CUR_W-1:0] v [7] = '{default: 16'h0000};
   logic [CUR_W-1:0] mq [7];
   logic [CUR_W-1:0] hi = 16'h0078, lo = 16'h000A, rdl = 16'h000A;
   logic [PCT_W-1:0] rat = RATIO_DEF, seq = SEQ_RATIO_DEF;
   logic [DLY_W-1:0] dly = 19'h00002;
   logic rsel = 1'b0, blk = 1'b0, clr = 1'b0, rd_en = 1'b0;
   logic [1:0] ssel = 2'h3;
   logic [GRP_W-1:0] grp = 3'h5;
   logic [TS_W-1:0] ts = 48'h000000001000;
   logic [IDX_W-1:0] age = 4'h0;
   logic start_ff, alarm_ff, blocked_ff;
   logic [FLT_W-1:0] cond_ff;
   logic [EVT_W-1:0] evt_ff;
   logic [TS_W-1:0] evt_stamp;
   logic [CNT_W-1:0] alarm_cnt_ff, block_cnt_ff;
   logic [IDX_W-1:0] rec_count_ff;
   logic [2:0] sts;
   ctsv_rec_t rec_rd_data, r;
   logic [TS_W-1:0] st [13];
   logic [4:0] e;
   int error_cnt = 0, n_compared = 0, seed = 90413, n;
   assign sts = {blocked_ff, alarm_ff, start_ff};
   ctsv_meas_model u_fe (.sys_clk(sys_clk), .per(per), .v(v), .meas_valid(meas_valid), .q(mq));
   ctsv_top #(.STEP_CYC(SC)) dut (.sys_clk(sys_clk), .nrst(nrst), .clk_en(clk_en),
      .meas_valid(meas_valid), .cur_l1(mq[0]), .cur_l2(mq[1]), .cur_l3(mq[2]),
      .measured_residual_current(mq[3]), .summed_residual_current(mq[4]),
      .seq_pos_current(mq[5]), .seq_neg_current(mq[6]), .phase_pickup_limit_high(hi),
      .phase_pickup_limit_low(lo), .phase_ratio_limit(rat), .sequence_unbalance_ratio(seq),
      .residual_diff_limit(rdl), .residual_sel(rsel), .alarm_delay(dly),
      .event_store_sel(ssel), .set_group(grp), .block_in(blk), .count_clear(clr),
      .time_stamp(ts), .rec_rd_en(rd_en), .rec_rd_age(age), .start_ff(start_ff),
      .alarm_ff(alarm_ff), .blocked_ff(blocked_ff), .cond_ff(cond_ff), .evt_ff(evt_ff),
      .evt_stamp_ff(evt_stamp), .alarm_cnt_ff(alarm_cnt_ff), .block_cnt_ff(block_cnt_ff),
      .rec_count_ff(rec_count_ff), .rec_rd_data(rec_rd_data));
   initial forever #5 sys_clk = ~sys_clk;
   always @(negedge sys_clk) ts <= ts + 48'h1;
   // ==========================================================
   // Helpers
   function automatic int rnd(input int m);
      return ($random(seed) & 32'h7FFFFFFF) % m;
   endfunction
   function automatic logic [4:0] exp_cond();
      int mx, mn, df, f;
      f = 32'(PCT_FULL);
      mx = v[0] > v[1] ? v[0] : v[1];
      mx = v[2] > mx ? v[2] : mx;
      mn = v[0] < v[1] ? v[0] : v[1];
      mn = v[2] < mn ? v[2] : mn;
      df = v[4] > v[3] ? v[4] - v[3] : v[3] - v[4];
      return {!rsel || df >= rdl, v[6] * f >= seq * v[5], mn * f <= rat * mx, mx >= lo, mx <= hi};
   endfunction
   task automatic chk(input logic [63:0] got, input logic [63:0] exp, input string m);
      n_compared++;
      if (got !== exp) begin
         error_cnt++;
         $display("CHECK FAILED at %0t: %s got %0h exp %0h", $time, m, got, exp);
      end
   endtask
   task automatic wrap_up();
      $display("Compared %0d, mismatches %0d", n_compared, error_cnt);
      if (error_cnt == 0 && n_compared > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask
   task automatic cyc(input int k);
      repeat (k) @(negedge sys_clk);
   endtask
   task automatic wt(input int w, input logic val, output int k);
      k = 0;
      do begin
         @(negedge sys_clk);
         k++;
      end while (sts[w] !== val && k < 60);
      if (sts[w] !== val) begin
         error_cnt++;
         $display("CHECK FAILED at %0t: status wait ran out", $time);
         wrap_up();
      end
   endtask
   task automatic ld(input int a, b, c, m, s, p, g);
      v = '{16'(a), 16'(b), 16'(c), 16'(m), 16'(s), 16'(p), 16'(g)};
   endtask
   task automatic settle();
      cyc(int'(per) + 4);
      e = exp_cond();
   endtask
   task automatic tcase(input int a, b, c, m, s, p, g);
      ld(a, b, c, m, s, p, g);
      settle();
      chk(cond_ff, e, "cond table");
      cyc(20);
      chk(alarm_ff, e == 5'h1F, "alarm");
   endtask
   task automatic rd(input int a);
      age = 4'(a);
      rd_en = 1'b1;
      cyc(1);
      r = rec_rd_data;
      rd_en = 1'b0;
      cyc(1);
   endtask
   // ==========================================================
   // Sequence
   initial begin
      cyc(20);
      chk({sts, cond_ff, evt_ff, rec_count_ff}, 0, "reset");
      nrst = 1'b1;
      cyc(2);
      for (int i = 0; i < 40; i++) begin
         foreach (v[j]) v[j] = 16'(rnd(160));
         rat = 14'(rnd(10000) + 1);
         seq = 14'(rnd(10000) + 1);
         rsel = 1'(rnd(2));
         rdl = 16'(rnd(40));
         per = 4'(rnd(8));
         settle();
         chk(cond_ff, e, "cond");
         chk(start_ff, e == 5'h1F, "start");
      end
      rat = RATIO_DEF;
      seq = SEQ_RATIO_DEF;
      rdl = 16'h000A;
      rsel = 1'b0;
      tcase(0, 200, 100, 0, 0, 67, 33);
      tcase(0, 5, 5, 0, 0, 67, 33);
      rsel = 1'b1;
      tcase(0, 100, 100, 20, 20, 67, 33);
      tcase(0, 100, 100, 0, 67, 67, 33);
      rsel = 1'b0;
      for (int d = 0; d <= 2; d += 2) begin
         dly = 19'(d);
         ssel = d == 0 ? 2'h1 : 2'h2;
         ld(100, 100, 100, 0, 0, 100, 0);
         settle();
         clr = 1'b1;
         cyc(1);
         clr = 1'b0;
         chk(alarm_cnt_ff, 0, "cleared");
         ld(0, 100, 100, 0, 0, 67, 33);
         wt(0, 1'b1, n);
         // Frozen cycles must not advance the timer
         clk_en = 1'b0;
         cyc(3);
         clk_en = 1'b1;
         wt(1, 1'b1, n);
         chk(n >= d * SC && n <= d * SC + 3, 1, "delay");
         st[0] = ts;
         if (ssel[0]) chk(evt_stamp, st[0], "event stamp");
         chk(evt_ff, {3'h0, ssel[0]}, "alarm on event");
         chk(alarm_cnt_ff, 1, "alarm count");
         rd(0);
         chk(r.stamp, st[0], "rec stamp");
         chk({r.event_code, r.cur_l1, r.cur_l2, r.seq_neg}, 52'h1_0000_0064_0021, "rec");
         chk({r.fault_code, r.set_group}, {5'h1F, grp}, "rec code");
         ld(100, 100, 100, 0, 0, 100, 0);
         wt(1, 1'b0, n);
         chk({start_ff, evt_ff}, {3'h0, ssel[1], 1'b0}, "release");
      end
      dly = 19'h00002;
      ssel = 2'h3;
      blk = 1'b1;
      ld(0, 100, 100, 0, 0, 67, 33);
      wt(2, 1'b1, n);
      chk({start_ff, evt_ff, block_cnt_ff}, 21'h04_0001, "block on");
      rd(0);
      chk({r.event_code, r.time_left}, {4'h4, dly}, "block rec");
      blk = 1'b0;
      wt(2, 1'b0, n);
      chk(evt_ff, 4'h8, "block off");
      wt(0, 1'b1, n);
      blk = 1'b1;
      cyc(1);
      chk({start_ff, blocked_ff}, 2'h1, "late block");
      for (int i = 0; i < 13; i++) begin
         blk = 1'b0;
         cyc(3);
         blk = 1'b1;
         st[i] = ts + 48'h1;
         cyc(3);
      end
      chk(rec_count_ff, 4'hC, "ring full");
      rd(0);
      chk(r.stamp, st[12], "newest");
      rd(11);
      chk(r.stamp, st[1], "oldest kept");
      wrap_up();
   end
endmodule // ctsv_top_tb
`default_nettype wire
